// [inc/sac_defines.svh]
// Summary of operation
// RL1: successive approximation builds a 10-bit result held in the result pair
// RL2: channel field picks one of up to 15 sources for the sample-and-hold
// RL3: software waits an acquisition delay after a channel change
// RL4: positive reference is pin, supply or fixed buffer; negative is ground
// RL5: 3-bit clock code picks sysclk/2 to /64 or the internal RC clock
// RL6: one conversion lasts 11.5 conversion bit periods
// RL7: in Sleep the converter runs only on the internal RC clock
// RL8: completion sets the done flag whatever the interrupt enable says
// RL9: hardware never clears the done flag; software must
// RL10: enabled completion interrupt wakes the device from Sleep
// RL11: resume in line without global enable; vector when all three are set
// RL12: format bit selects left or right justified result
// RL13: temperature indicator is powered only while its enable is set
// RL14: range bit set gives four-junction drop, clear gives two
// RL15: temperature indicator sits on its own internal converter channel
// RL16: software waits 200 us before and between temperature conversions
// RL17: on completion clear busy, set flag and load the result
// RL18: early busy clear stops and stores partial, low bits copy last bit
// RL19: rising edge of the chosen trigger source sets busy
// RL20: codes 1D/1E/1F are temp, DAC, fixed buffer; 0C..1C unconnected
// RL21: right keeps bits in low ten, left in high ten, rest zero
// RL22: divided clocks come from the system clock synchronously
`ifndef SAC_DEFINES_SVH
`define SAC_DEFINES_SVH
`define SAC_RES_W 10
`define SAC_OFS_CTRL0 4'h0
`define SAC_OFS_CTRL1 4'h1
`define SAC_OFS_CTRL2 4'h2
`define SAC_OFS_RESH 4'h3
`define SAC_OFS_RESL 4'h4
`define SAC_OFS_REFTS 4'h5
`define SAC_OFS_INTC 4'h6
`define SAC_C0_ON 0
`define SAC_C0_GO 1
`define SAC_C0_CHS 6:2
`define SAC_C1_FM 7
`define SAC_C1_CS 6:4
`define SAC_C1_PREF 1:0
`define SAC_C2_TRIG 3:0
`define SAC_RT_FIXED_REFERENCE_ENABLE 7
`define SAC_RT_RDY 6
`define SAC_RT_TEMP_INDICATOR_ENABLE 5
`define SAC_RT_TEMP_INDICATOR_RANGE 4
`define SAC_RT_CDA 3:2
`define SAC_RT_ADG 1:0
`define SAC_IC_FLAG 0
`define SAC_IC_IE 1
`define SAC_IC_PERIPHERAL_INTERRUPT_ENABLE 2
`define SAC_IC_GIE 3
`define SAC_CH_LAST_PIN 5'h0B
`define SAC_CH_TEMP 5'h1D
`define SAC_CH_DAC 5'h1E
`define SAC_CH_FVR 5'h1F
`define SAC_CS_FRC 2'h3
`define SAC_REF_VDD 2'h0
`define SAC_REF_EXT 2'h2
`define SAC_REF_FVR 2'h3
`define SAC_HALF_SAMPLE_END 5'h02
`define SAC_HALF_LAST 5'h16
`define SAC_RST8 8'h00
`endif

// [inc/sac_pkg.sv]
package sac_pkg;
  typedef enum logic [2:0] {
    SAC_IDLE = 3'h1,
    SAC_SAMPLE = 3'h2,
    SAC_CONV = 3'h4
  } sac_state_t;
endpackage

// [logic/sac_tad_gen.sv]
`timescale 1ns/1ps
`include "sac_defines.svh"
module sac_tad_gen
#(parameter int CW = 6)
(
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic run,
  input wire logic [2:0] clk_sel,
  input wire logic frc_edge,
  output logic half_tick_q
);
  logic [CW-1:0] cnt_q;
  logic [CW-1:0] limit;
  logic [2:0] idx;
  logic internal_rc_conversion_clock;
  // code order 000,100,001,101,010,110 maps to half-period 1,2,4..32
  assign idx = {clk_sel[1:0], clk_sel[2]};
  assign limit = CW'((1 << idx) - 1); // RL5
  assign internal_rc_conversion_clock = clk_sel[1:0] == `SAC_CS_FRC;
  // counter held in reset while idle so each conversion starts aligned
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      cnt_q <= '0;
      half_tick_q <= 1'b0;
    end
    else if (ce)
    begin
      if (!run)
      begin
        cnt_q <= '0;
        half_tick_q <= 1'b0;
      end
      else if (internal_rc_conversion_clock)
      begin
        half_tick_q <= frc_edge; // RL5
      end
      else if (cnt_q >= limit)
      begin
        cnt_q <= '0;
        half_tick_q <= 1'b1; // RL22
      end
      else
      begin
        cnt_q <= cnt_q + CW'(1);
        half_tick_q <= 1'b0;
      end
    end
  end
endmodule

// [logic/sac_sar.sv]
`timescale 1ns/1ps
module sac_sar
#(parameter int W = 10)
(
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic load,
  input wire logic step,
  input wire logic cmp_hi,
  output logic [W-1:0] trial_q,
  output logic [W-1:0] value_q,
  output logic [W-1:0] partial,
  output logic last
);
  logic [W-1:0] mask_q;
  logic [W-1:0] sar_d;
  logic [W-1:0] low;
  logic fill;
  assign sar_d = cmp_hi ? (value_q | mask_q) : value_q; // RL1
  assign last = mask_q[0];
  // region still unresolved takes the last decided bit
  assign low = mask_q | (mask_q - W'(1));
  assign fill = |(value_q & (mask_q << 1));
  assign partial = (value_q & ~low) | ({W{fill}} & low); // RL18
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      mask_q <= '0;
      value_q <= '0;
      trial_q <= '0;
    end
    else if (ce)
    begin
      if (load)
      begin
        mask_q <= {1'b1, {(W-1){1'b0}}};
        value_q <= '0;
        trial_q <= {1'b1, {(W-1){1'b0}}};
      end
      else if (step)
      begin
        mask_q <= mask_q >> 1;
        value_q <= sar_d;
        trial_q <= sar_d | (mask_q >> 1); // RL1
      end
    end
  end
endmodule

// [logic/sac_top.sv]
// The address-and-strobe port and the register offsets are this design's own decisions.
`timescale 1ns/1ps
`include "sac_defines.svh"
module sac_top
  import sac_pkg::*;
#(parameter int TRIG_W = 16)
(
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata_q,
  input wire logic sleep,
  input wire logic frc_clk_in,
  input wire logic cmp_hi_in,
  input wire logic fvr_ready_in,
  input wire logic [TRIG_W-1:0] trig_in,
  output logic [`SAC_RES_W-1:0] dac_trial_q,
  output logic hold_q,
  output logic [4:0] channel_select_q,
  output logic channel_connected_q,
  output logic [2:0] ref_pick_q,
  output logic converter_powered_q,
  output logic fixed_reference_enable_q,
  output logic [1:0] comparator_ref_gain_q,
  output logic [1:0] converter_ref_gain_q,
  output logic temp_indicator_enable_q,
  output logic temp_indicator_range_q,
  output logic wake_q,
  output logic isr_vector_q
);
  sac_state_t state_q;
  logic on_q, go_q, fm_q, flag_q, ie_q, peripheral_interrupt_enable_q, gie_q;
  logic [2:0] cs_q;
  logic [1:0] pref_q;
  logic [3:0] trig_sel_q;
  logic [`SAC_RES_W-1:0] result_q;
  logic [4:0] half_q;
  logic [1:0] s1_q, s2_q;
  logic frc_prev_q, trig_prev_q, finish_q, off_after_q;
  logic wr0, wr1, wr2, wr_rt, wr_ic;
  logic frc_sel, frc_edge, tick, busy, trig_cur, start, step;
  logic abort_sw, abort_slp, abort;
  logic [`SAC_RES_W-1:0] sar_value, sar_partial;
  logic sar_last;
  logic [7:0] rd_d;
  logic [15:0] fmt;

  assign wr0 = reg_wr && reg_addr == `SAC_OFS_CTRL0;
  assign wr1 = reg_wr && reg_addr == `SAC_OFS_CTRL1;
  assign wr2 = reg_wr && reg_addr == `SAC_OFS_CTRL2;
  assign wr_rt = reg_wr && reg_addr == `SAC_OFS_REFTS;
  assign wr_ic = reg_wr && reg_addr == `SAC_OFS_INTC;
  // bit 0 fixed ref ready, 1 RC clock
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      s1_q <= 2'h0;
      s2_q <= 2'h0;
      frc_prev_q <= 1'b0;
    end
    else if (ce)
    begin
      s1_q <= {frc_clk_in, fvr_ready_in};
      s2_q <= s1_q;
      frc_prev_q <= s2_q[1];
    end
  end
  // comparator tracks our own trial code; a sync lag breaks /2 decisions
  assign frc_edge = s2_q[1] && !frc_prev_q;
  assign frc_sel = cs_q[1:0] == `SAC_CS_FRC;
  assign busy = state_q != SAC_IDLE;

  assign trig_cur = trig_in[trig_sel_q];
  assign start = !busy && !go_q && on_q && !(sleep && !frc_sel)
    && ((wr0 && reg_wdata[`SAC_C0_GO]) || (trig_cur && !trig_prev_q)); // RL19
  assign abort_sw = busy && wr0
    && (!reg_wdata[`SAC_C0_GO] || !reg_wdata[`SAC_C0_ON]); // RL18
  assign abort_slp = busy && sleep && !frc_sel; // RL7
  assign abort = abort_sw || abort_slp;
  assign step = tick && state_q == SAC_CONV && !half_q[0];
  sac_tad_gen #(.CW(6)) u_sac_tad_gen (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .ce(ce),
    .run(busy),
    .clk_sel(cs_q),
    .frc_edge(frc_edge),
    .half_tick_q(tick)
  );
  sac_sar #(.W(`SAC_RES_W)) u_sac_sar (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .ce(ce),
    .load(start),
    .step(step),
    .cmp_hi(cmp_hi_in),
    .trial_q(dac_trial_q),
    .value_q(sar_value),
    .partial(sar_partial),
    .last(sar_last)
  );
  // 1.5 bit periods of sampling then two half periods per bit
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      state_q <= SAC_IDLE;
      half_q <= 5'h00;
      finish_q <= 1'b0;
      trig_prev_q <= 1'b0;
    end
    else if (ce)
    begin
      trig_prev_q <= trig_cur;
      finish_q <= step && sar_last && !abort; // RL6
      if (tick)
        half_q <= half_q + 5'h01;
      case (state_q)
        SAC_IDLE:
        begin
          half_q <= 5'h00;
          if (start)
            state_q <= SAC_SAMPLE;
        end
        SAC_SAMPLE:
        begin
          if (abort)
            state_q <= SAC_IDLE;
          else if (tick && half_q == `SAC_HALF_SAMPLE_END)
            state_q <= SAC_CONV; // RL6
        end
        SAC_CONV:
        begin
          if (abort || (step && sar_last))
            state_q <= SAC_IDLE; // RL6
        end
        default:
          state_q <= SAC_IDLE;
      endcase
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      on_q <= 1'b0;
      go_q <= 1'b0;
      channel_select_q <= 5'h00;
    end
    else if (ce)
    begin
      if (wr0)
      begin
        on_q <= reg_wdata[`SAC_C0_ON];
        channel_select_q <= reg_wdata[`SAC_C0_CHS]; // RL2
      end
      if (start)
        go_q <= 1'b1; // RL19
      else if (finish_q || abort || (wr0 && !reg_wdata[`SAC_C0_GO]))
        go_q <= 1'b0; // RL17
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      fm_q <= 1'b0;
      cs_q <= 3'h0;
      pref_q <= `SAC_REF_VDD;
      trig_sel_q <= 4'h0;
    end
    else if (ce)
    begin
      if (wr1)
      begin
        fm_q <= reg_wdata[`SAC_C1_FM]; // RL12
        cs_q <= reg_wdata[`SAC_C1_CS]; // RL5
        pref_q <= reg_wdata[`SAC_C1_PREF];
      end
      if (wr2)
        trig_sel_q <= reg_wdata[`SAC_C2_TRIG];
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      fixed_reference_enable_q <= 1'b0;
      temp_indicator_enable_q <= 1'b0;
      temp_indicator_range_q <= 1'b0;
      comparator_ref_gain_q <= 2'h0;
      converter_ref_gain_q <= 2'h0;
    end
    else if (ce && wr_rt)
    begin
      fixed_reference_enable_q <= reg_wdata[`SAC_RT_FIXED_REFERENCE_ENABLE];
      temp_indicator_enable_q <= reg_wdata[`SAC_RT_TEMP_INDICATOR_ENABLE]; // RL13
      temp_indicator_range_q <= reg_wdata[`SAC_RT_TEMP_INDICATOR_RANGE]; // RL14
      comparator_ref_gain_q <= reg_wdata[`SAC_RT_CDA];
      converter_ref_gain_q <= reg_wdata[`SAC_RT_ADG];
    end
  end

  // a completion landing on a software clear still sets the flag
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      flag_q <= 1'b0;
      ie_q <= 1'b0;
      peripheral_interrupt_enable_q <= 1'b0;
      gie_q <= 1'b0;
    end
    else if (ce)
    begin
      if (finish_q)
        flag_q <= 1'b1; // RL8
      else if (wr_ic)
        flag_q <= reg_wdata[`SAC_IC_FLAG]; // RL9
      if (wr_ic)
      begin
        ie_q <= reg_wdata[`SAC_IC_IE];
        peripheral_interrupt_enable_q <= reg_wdata[`SAC_IC_PERIPHERAL_INTERRUPT_ENABLE];
        gie_q <= reg_wdata[`SAC_IC_GIE];
      end
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
      result_q <= '0;
    else if (ce)
    begin
      if (finish_q)
        result_q <= sar_value; // RL17
      else if (abort_sw)
        result_q <= sar_partial; // RL18
    end
  end

  // on-bit stays set while the analog side is powered down in Sleep
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      off_after_q <= 1'b0;
      converter_powered_q <= 1'b0;
      wake_q <= 1'b0;
      isr_vector_q <= 1'b0;
      hold_q <= 1'b0;
      channel_connected_q <= 1'b0;
      ref_pick_q <= 3'h1;
    end
    else if (ce)
    begin
      if (!sleep)
        off_after_q <= 1'b0;
      else if (finish_q && !ie_q)
        off_after_q <= 1'b1;
      converter_powered_q <= on_q && !(sleep && (!frc_sel || off_after_q));
      wake_q <= sleep && flag_q && ie_q; // RL10
      isr_vector_q <= flag_q && ie_q && peripheral_interrupt_enable_q && gie_q; // RL11
      hold_q <= state_q == SAC_CONV;
      channel_connected_q <= channel_select_q <= `SAC_CH_LAST_PIN
        || channel_select_q >= `SAC_CH_TEMP; // RL15 RL20
      // negative reference is always ground, so only ref+ is steered
      if (pref_q == `SAC_REF_FVR)
        ref_pick_q <= 3'h4; // RL4
      else if (pref_q == `SAC_REF_EXT)
        ref_pick_q <= 3'h2;
      else
        ref_pick_q <= 3'h1;
    end
  end

  // right: {6'0,r} ; left: {r,6'0} across high:low
  assign fmt = fm_q ? {6'h00, result_q} : {result_q, 6'h00}; // RL21
  always_comb
  begin
    rd_d = `SAC_RST8;
    if (reg_addr == `SAC_OFS_CTRL0)
      rd_d = {1'b0, channel_select_q, go_q, on_q};
    else if (reg_addr == `SAC_OFS_CTRL1)
      rd_d = {fm_q, cs_q, 2'h0, pref_q};
    else if (reg_addr == `SAC_OFS_CTRL2)
      rd_d = {4'h0, trig_sel_q};
    else if (reg_addr == `SAC_OFS_RESH)
      rd_d = fmt[15:8]; // RL12
    else if (reg_addr == `SAC_OFS_RESL)
      rd_d = fmt[7:0];
    else if (reg_addr == `SAC_OFS_REFTS)
      rd_d = {fixed_reference_enable_q,
              fixed_reference_enable_q && s2_q[0],
              temp_indicator_enable_q, temp_indicator_range_q,
              comparator_ref_gain_q, converter_ref_gain_q};
    else if (reg_addr == `SAC_OFS_INTC)
      rd_d = {4'h0, gie_q, peripheral_interrupt_enable_q, ie_q, flag_q};
  end
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
      reg_rdata_q <= `SAC_RST8;
    else if (ce)
      reg_rdata_q <= reg_rd ? rd_d : `SAC_RST8;
  end
  property p_flag_set;
    @(posedge ref_clk) disable iff (!rst_n || !ce)
    finish_q |=> flag_q;
  endproperty
  a_flag_set: assert property (p_flag_set) // RL8
    else $error("done flag not set after completion");
  property p_go_clr;
    @(posedge ref_clk) disable iff (!rst_n || !ce)
    finish_q |=> !go_q && state_q == SAC_IDLE;
  endproperty
  a_go_clr: assert property (p_go_clr) // RL17
    else $error("busy bit still set after completion");
  property p_res_load;
    @(posedge ref_clk) disable iff (!rst_n || !ce)
    finish_q |=> result_q == $past(sar_value);
  endproperty
  a_res_load: assert property (p_res_load) // RL1
    else $error("result not loaded on completion");
  property p_length;
    @(posedge ref_clk) disable iff (!rst_n || !ce)
    step && sar_last |-> half_q == `SAC_HALF_LAST;
  endproperty
  a_length: assert property (p_length) // RL6
    else $error("conversion length is not 11.5 bit periods");
  property p_sleep_stop;
    @(posedge ref_clk) disable iff (!rst_n || !ce)
    busy && sleep && !frc_sel |=> state_q == SAC_IDLE ##1 !go_q;
  endproperty
  a_sleep_stop: assert property (p_sleep_stop) // RL7
    else $error("conversion kept running in Sleep off RC clock");
  property p_wake;
    @(posedge ref_clk) disable iff (!rst_n || !ce)
    sleep && flag_q && ie_q |=> wake_q;
  endproperty
  a_wake: assert property (p_wake) // RL10
    else $error("no wake on enabled completion in Sleep");
  property p_vector;
    @(posedge ref_clk) disable iff (!rst_n || !ce)
    isr_vector_q |-> $past(gie_q) && $past(peripheral_interrupt_enable_q) && $past(ie_q);
  endproperty
  a_vector: assert property (p_vector) // RL11
    else $error("vector raised without all three enables");
  property p_trig;
    @(posedge ref_clk) disable iff (!rst_n || !ce)
    start && !wr0 |=> go_q ##1 busy;
  endproperty
  a_trig: assert property (p_trig) // RL19
    else $error("trigger edge did not start a conversion");
  property p_right_fmt;
    @(posedge ref_clk) disable iff (!rst_n || !ce)
    reg_rd && reg_addr == `SAC_OFS_RESH && fm_q
      |=> reg_rdata_q[7:2] == 6'h00;
  endproperty
  a_right_fmt: assert property (p_right_fmt) // RL21
    else $error("right justified high byte has upper bits set");
endmodule

// [verification/sac_analog_model.sv]
`timescale 1ns/1ps
module sac_analog_model
(
  input wire logic ref_clk,
  input wire logic [9:0] trial,
  input wire logic [4:0] chan,
  input wire logic connected,
  input wire logic temp_on,
  input wire logic temp_hi,
  input wire logic fvr_on,
  input wire logic [9:0] pin_level,
  output logic cmp_hi,
  output logic frc_clk,
  output logic fvr_ready
);
  logic [9:0] level;
  logic [3:0] settle_q;
  initial frc_clk = 1'b0;
  // rc oscillator free runs, phase unrelated to ref_clk
  always #185 frc_clk = ~frc_clk;
  always_comb
  begin
    if (!connected)
      level = 10'h000;
    else if (chan <= 5'h0B)
      level = pin_level;
    else if (chan == 5'h1D)
      level = !temp_on ? 10'h000 : (temp_hi ? 10'h1C6 : 10'h2B3);
    else if (chan == 5'h1E)
      level = 10'h155;
    else
      level = 10'h0AA;
  end
  // ideal comparator: sar then converges on level exactly
  assign cmp_hi = level >= trial;
  always @(posedge ref_clk)
    if (!fvr_on)
      settle_q <= 4'h0;
    else if (settle_q != 4'hF)
      settle_q <= settle_q + 4'h1;
  assign fvr_ready = settle_q == 4'hF;
endmodule

// [verification/sac_top_tb.sv]
`timescale 1ns/1ps
module sac_top_tb;
  localparam int ACQ = 20;
  localparam logic [2:0] CS_TAB [0:5] = '{3'h0, 3'h4, 3'h1, 3'h5, 3'h2, 3'h6};
  logic ref_clk = 1'b0, rst_n = 1'b0, ce = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
  logic sleep = 1'b0;
  logic [3:0] reg_addr = 4'h0;
  logic [7:0] reg_wdata = 8'h00, d;
  logic [15:0] trig_in = 16'h0000;
  logic [9:0] pin_level = 10'h2A5;
  wire [7:0] reg_rdata_q;
  wire [9:0] dac_trial_q;
  wire [4:0] channel_select;
  wire [2:0] ref_pick_q;
  wire [1:0] cga, aga;
  wire cmp, internal_rc_conversion_clock, rdy, hold, conn, pwr, fen, ten, trg, wake, vec;
  int n_fail = 0, checked = 0, cyc = 0, t0, dt;
  always #50 ref_clk = ~ref_clk;
  always @(posedge ref_clk) cyc <= cyc + 1;
  sac_top u_sac_top (.ref_clk(ref_clk), .rst_n(rst_n), .ce(ce),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata_q(reg_rdata_q), .sleep(sleep),
    .frc_clk_in(internal_rc_conversion_clock), .cmp_hi_in(cmp), .fvr_ready_in(rdy),
    .trig_in(trig_in), .dac_trial_q(dac_trial_q), .hold_q(hold),
    .channel_select_q(channel_select), .channel_connected_q(conn),
    .ref_pick_q(ref_pick_q), .converter_powered_q(pwr),
    .fixed_reference_enable_q(fen), .comparator_ref_gain_q(cga),
    .converter_ref_gain_q(aga), .temp_indicator_enable_q(ten),
    .temp_indicator_range_q(trg), .wake_q(wake), .isr_vector_q(vec));
  sac_analog_model u_sac_analog_model (.ref_clk(ref_clk),
    .trial(dac_trial_q), .chan(channel_select), .connected(conn), .temp_on(ten),
    .temp_hi(trg), .fvr_on(fen), .pin_level(pin_level), .cmp_hi(cmp),
    .frc_clk(internal_rc_conversion_clock), .fvr_ready(rdy));
  task automatic results;
    $display("checked %0d n_fail %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [9:0] e, input logic [9:0] g);
    checked++;
    if (g !== e)
    begin
      n_fail++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] v);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, output logic [7:0] v);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    @(posedge ref_clk);
    v = reg_rdata_q;
  endtask
  // on set first, channel settles, then go with the given interrupt bits
  task automatic start(input logic [4:0] ch, input logic [7:0] c1,
    input logic [7:0] ic, input logic go);
    wr(4'h1, c1);
    wr(4'h0, {1'b0, ch, 2'b01});
    repeat (ACQ) @(posedge ref_clk);
    wr(4'h6, ic);
    if (go)
      wr(4'h0, {1'b0, ch, 2'b11});
    t0 = cyc;
  endtask
  task automatic wait_done;
    int i;
    for (i = 0; i < 1000; i++)
    begin
      rd(4'h0, d);
      if (d[1] === 1'b0)
        break;
    end
    dt = cyc - t0;
    if (i == 1000)
    begin
      n_fail++;
      $display("BAD go_wait expected 0 seen 1");
      results();
    end
  endtask
  // expected pair from the 10-bit value and the format bit
  task automatic res(input logic [9:0] r, input logic fm);
    rd(4'h3, d);
    chk("res_hi", fm ? {8'h00, r[9:8]} : {2'b00, r[9:2]}, {2'b00, d});
    rd(4'h4, d);
    chk("res_lo", fm ? {2'b00, r[7:0]} : {2'b00, r[1:0], 6'h00}, {2'b00, d});
  endtask
  initial
  begin
    int i;
    repeat (8) @(posedge ref_clk);
    rst_n <= 1'b1;
    for (i = 0; i < 7; i++)
    begin
      rd(i[3:0], d);
      chk("reset_reg", 10'h000, {2'b00, d});
    end
    chk("ref_pick", 10'h001, {7'h00, ref_pick_q});
    wr(4'hA, 8'h5A);
    rd(4'hA, d);
    chk("unmapped", 10'h000, {2'b00, d});
    $display("test reset done");
    for (i = 0; i < 4; i++)
    begin
      wr(4'h1, {6'h00, i[1:0]});
      repeat (2) @(posedge ref_clk);
      chk("ref_pick", i == 2 ? 10'h2 : (i == 3 ? 10'h4 : 10'h1), {7'h00, ref_pick_q});
    end
    for (i = 11; i < 32; i++)
    begin
      wr(4'h0, {1'b0, i[4:0], 2'b00});
      repeat (2) @(posedge ref_clk);
      chk("chan", i[9:0], {5'h00, channel_select});
      chk("connected", (i <= 11 || i >= 29) ? 10'h1 : 10'h0, {9'h000, conn});
    end
    $display("test mux done");
    wr(4'h5, 8'hBF);
    repeat (24) @(posedge ref_clk);
    rd(4'h5, d);
    chk("ref_temp", 10'h0FF, {2'b00, d});
    chk("temp_outs", 10'h3FF, {fen, ten, trg, cga, aga, 3'h7});
    wr(4'h5, 8'h00);
    rd(4'h5, d);
    chk("ref_temp", 10'h000, {2'b00, d});
    chk("temp_off", 10'h000, {9'h000, ten});
    $display("test ref_temp done");
    for (i = 0; i < 6; i++)
    begin
      pin_level <= 10'h2A5 ^ i[9:0];
      start(5'h03, {1'b1, CS_TAB[i], 4'h0}, 8'h00, 1'b1);
      wait_done();
      checked++;
      if (dt < 23 * (1 << i) - 2 || dt > 23 * (1 << i) + 12)
      begin
        n_fail++;
        $display("BAD conv_time expected %0d seen %0d", 23 * (1 << i), dt);
      end
      rd(4'h6, d);
      chk("flag_no_ie", 10'h001, {9'h000, d[0]});
      res(10'h2A5 ^ i[9:0], 1'b1);
      rd(4'h6, d);
      chk("flag_held", 10'h001, {9'h000, d[0]});
    end
    $display("test clocks done");
    for (i = 0; i < 2; i++)
    begin
      wr(4'h5, {2'b00, 1'b1, i[0], 4'h0});
      start(5'h1D, 8'h00, 8'h00, 1'b0);
      repeat (2000) @(posedge ref_clk);
      wr(4'h0, {1'b0, 5'h1D, 2'b11});
      wait_done();
      res(i == 1 ? 10'h1C6 : 10'h2B3, 1'b0);
    end
    $display("test temp done");
    pin_level <= 10'h2A5;
    start(5'h02, 8'hE0, 8'h00, 1'b1);
    repeat (300) @(posedge ref_clk);
    chk("hold", 10'h001, {9'h000, hold});
    chk("powered", 10'h001, {9'h000, pwr});
    wr(4'h0, {1'b0, 5'h02, 2'b01});
    rd(4'h0, d);
    chk("abort_go", 10'h000, {9'h000, d[1]});
    chk("hold_idle", 10'h000, {9'h000, hold});
    res(10'h2FF, 1'b1);
    wr(4'h2, 8'h03);
    start(5'h02, 8'h80, 8'h00, 1'b0);
    trig_in <= 16'h0008;
    @(posedge ref_clk);
    trig_in <= 16'h0000;
    rd(4'h0, d);
    chk("trig_go", 10'h001, {9'h000, d[1]});
    wait_done();
    res(10'h2A5, 1'b1);
    wr(4'h2, 8'h00);
    $display("test abort_trig done");
    start(5'h02, 8'hE0, 8'h00, 1'b1);
    repeat (60) @(posedge ref_clk);
    sleep <= 1'b1;
    repeat (4) @(posedge ref_clk);
    chk("sleep_off", 10'h000, {9'h000, pwr});
    sleep <= 1'b0;
    rd(4'h0, d);
    chk("sleep_abort_go", 10'h000, {9'h000, d[1]});
    rd(4'h6, d);
    chk("sleep_abort_flag", 10'h000, {9'h000, d[0]});
    start(5'h02, 8'hB0, 8'h00, 1'b0);
    sleep <= 1'b1;
    wr(4'h0, {1'b0, 5'h02, 2'b11});
    wait_done();
    repeat (2) @(posedge ref_clk);
    chk("rc_off", 10'h000, {9'h000, pwr});
    chk("no_wake", 10'h000, {9'h000, wake});
    sleep <= 1'b0;
    start(5'h02, 8'hB0, 8'h06, 1'b0);
    sleep <= 1'b1;
    wr(4'h0, {1'b0, 5'h02, 2'b11});
    wait_done();
    repeat (2) @(posedge ref_clk);
    chk("wake", 10'h001, {9'h000, wake});
    chk("inline", 10'h000, {9'h000, vec});
    chk("awake_on", 10'h001, {9'h000, pwr});
    res(10'h2A5, 1'b1);
    wr(4'h6, 8'h0F);
    repeat (2) @(posedge ref_clk);
    chk("vector", 10'h001, {9'h000, vec});
    sleep <= 1'b0;
    $display("test sleep done");
    results();
  end
endmodule
